// [sbt_seq_trigger.sv]
// Purpose: Real-time sequential breakpoint trigger with pass count,
//   A-to-B timeout and post-trigger trace extension.
// Assumes: Matches are one-cycle pulses, settings steady while running.
// Notes: Outputs are registered.
`timescale 1ns/100ps
`default_nettype none
`include "sbt_cfg.svh"

module sbt_seq_trigger (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Comparator matches
  input wire logic [9:0] bp_match,
  // Settings
  input wire logic seq_enable,
  input wire logic [2:0] cond_sel,
  input wire sbt_pkg::sbt_map_s term_map,
  input wire logic [7:0] pass_count,
  input wire logic trace_after,
  input wire sbt_pkg::sbt_time_s timeout,
  // Target control and trace
  output logic stop_req,
  output logic [9:0] bp_stop,
  output logic trace_run,
  output logic [1:0] arm_state,
  output logic [7:0] pass_left
);

  typedef enum logic [2:0] {
    SBT_IDLE = 3'b001,
    SBT_ARM1 = 3'b010,
    SBT_ARM2 = 3'b100
  } sbt_st_e;

  sbt_pkg::sbt_terms_s t;
  logic [9:0] solo;
  sbt_st_e st;
  sbt_st_e next_st;
  logic [7:0] pass_cnt;
  logic [7:0] trace_cnt;
  logic tracing;
  logic timing;
  logic [6:0] us_div;
  // Wide enough for 255 minutes counted in microseconds
  logic [39:0] us_cnt;

  sbt_term_map u_map (
    .bp_match(bp_match),
    .term_map(term_map),
    .seq_enable(seq_enable),
    .terms(t),
    .bp_solo(solo)
  );

  ////////////////////////////////////////////////////////////////////////
  // Condition decode

  wire is_to = (cond_sel == 3'(sbt_pkg::SBT_COND_TIMEOUT));
  wire [39:0] limit_us = 40'(timeout.minutes) * 40'(`SBT_US_PER_MIN)
                       + 40'(timeout.seconds) * 40'(`SBT_US_PER_SEC)
                       + 40'(timeout.millis) * 40'(`SBT_US_PER_MS)
                       + 40'(timeout.micros);
  wire us_tick = (us_div == 7'(`SBT_US_CYCLES - 1));
  wire to_hit = timing && !t.b && (us_cnt >= limit_us) && !t.a;
  // Pass count of zero behaves as one; timeout forces one
  wire [7:0] pass_load = (is_to || pass_count == 8'h0_000) ? 8'h0_001 : pass_count;
  wire st_idle = (st == SBT_IDLE);
  wire st_a1 = (st == SBT_ARM1);
  wire st_a2 = (st == SBT_ARM2);

  logic occur;
  always_comb begin
    next_st = st;
    occur = 1'b0;
    case (cond_sel)
      3'h1: begin
        occur = t.a | t.b | t.c | t.d;
      end
      3'h2: begin
        if (st_a1 && t.c) next_st = SBT_IDLE;
        else if (st_a1 && t.b) begin
          occur = 1'b1;
          next_st = SBT_IDLE;
        end else if (t.a) next_st = SBT_ARM1;
      end
      3'h3: begin
        if (!st_idle && t.d) next_st = SBT_IDLE;
        else if (st_a2 && t.c) begin
          occur = 1'b1;
          next_st = SBT_IDLE;
        end else if (st_a1 && t.b) next_st = SBT_ARM2;
        else if (st_idle && t.a) next_st = SBT_ARM1;
      end
      3'h4: begin
        if (st_a1 && t.d) next_st = SBT_IDLE;
        else if (st_a1 && (t.b || t.c)) begin
          occur = 1'b1;
          next_st = SBT_IDLE;
        end else if (t.a) next_st = SBT_ARM1;
      end
      3'h5: begin
        if (st_a1 && t.d) next_st = SBT_IDLE;
        else if (st_a1 && t.c) begin
          occur = 1'b1;
          next_st = SBT_IDLE;
        end else if (t.a || t.b) next_st = SBT_ARM1;
      end
      3'h6: begin
        occur = to_hit;
        next_st = SBT_IDLE;
      end
      default: begin
        next_st = SBT_IDLE;
      end
    endcase
    if (!seq_enable) begin
      next_st = SBT_IDLE;
      occur = 1'b0;
    end
  end

  // Timeout traps at once even if a larger count is still loaded
  wire trap = occur && (is_to || pass_cnt <= 8'h0_001);

  ////////////////////////////////////////////////////////////////////////
  // State, pass counter, timer

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= SBT_IDLE;
      pass_cnt <= 8'h0_001;
    end else begin
      st <= trap ? SBT_IDLE : next_st;
      if (!seq_enable || trap) pass_cnt <= pass_load;
      else if (occur) pass_cnt <= pass_cnt - 8'h0_001;
      else if (st_idle && pass_cnt == 8'h0_000) pass_cnt <= pass_load;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      timing <= 1'b0;
      us_div <= 7'h0_00;
      us_cnt <= 40'h00_0000_0000;
    end else if (!seq_enable || !is_to || trap || (timing && t.b && !t.a)) begin
      timing <= 1'b0;
      us_div <= 7'h0_00;
      us_cnt <= 40'h00_0000_0000;
    end else if (t.a) begin
      timing <= 1'b1;
      us_div <= 7'h0_00;
      us_cnt <= 40'h00_0000_0000;
    end else if (timing) begin
      us_div <= us_tick ? 7'h0_00 : us_div + 7'h0_01;
      if (us_tick) us_cnt <= us_cnt + 40'h00_0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs and trace extension

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tracing <= 1'b0;
      trace_cnt <= 8'h0_000;
      trace_run <= 1'b1;
    end else if (trap && trace_after && !is_to) begin
      tracing <= 1'b1;
      trace_cnt <= 8'(`SBT_TRACE_EXT_CYCLES - 1);
      trace_run <= 1'b1;
    end else if (trap) begin
      tracing <= 1'b0;
      trace_run <= 1'b0;
    end else if (tracing) begin
      trace_cnt <= trace_cnt - 8'h0_001;
      if (trace_cnt == 8'h0_000) begin
        tracing <= 1'b0;
        trace_run <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stop_req <= 1'b0;
      bp_stop <= 10'h0_000;
      arm_state <= 2'h0;
      pass_left <= 8'h0_001;
    end else begin
      stop_req <= trap;
      bp_stop <= solo;
      arm_state <= {st_a2, st_a1};
      pass_left <= pass_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  a_disabled_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    !seq_enable ##1 !seq_enable |=> !stop_req)
    else $error("Trap while disabled");

  a_any_fires: assert property (@(posedge clk) disable iff (!rst_n)
    (seq_enable && cond_sel == 3'h1 && (t.a || t.b) && pass_cnt == 8'h0_001) |=> stop_req)
    else $error("Condition one missed a match");

  a_unarmed_b: assert property (@(posedge clk) disable iff (!rst_n)
    (cond_sel == 3'h2 && st_idle) |-> !occur)
    else $error("Condition two fired unarmed");

  a_reset_clears: assert property (@(posedge clk) disable iff (!rst_n)
    (seq_enable && cond_sel == 3'h2 && st_a1 && t.c) |=> st_idle)
    else $error("Reset term did not clear arming");

  a_chain_step: assert property (@(posedge clk) disable iff (!rst_n)
    (seq_enable && cond_sel == 3'h3 && st_a1 && t.b && !t.d) |=> st_a2)
    else $error("Chain did not advance");

  a_trap_idle: assert property (@(posedge clk) disable iff (!rst_n)
    trap |=> st_idle && pass_cnt == $past(pass_load))
    else $error("No return to idle after trap");

  a_trace_freeze: assert property (@(posedge clk) disable iff (!rst_n)
    (trap && trace_after && !is_to) |=> trace_run [*8] ##121 !trace_run)
    else $error("Trace extension length wrong");

  a_timeout_trace: assert property (@(posedge clk) disable iff (!rst_n)
    (trap && is_to) |=> !trace_run)
    else $error("Timeout trap kept tracing");

  a_solo_masked: assert property (@(posedge clk) disable iff (!rst_n)
    (seq_enable && term_map.map_a == 4'h0) |=> !bp_stop[0])
    else $error("Mapped breakpoint stopped alone");

endmodule : sbt_seq_trigger
`default_nettype wire

// [sbt_cfg.svh]
// Purpose: Constants for the sequential breakpoint trigger.
// Assumes: 125 MHz clock.
// Notes: Times in their own units, cycle counts derived.
`ifndef SBT_CFG_SVH
`define SBT_CFG_SVH

`define SBT_CLK_MHZ 125
`define SBT_US_CYCLES (`SBT_CLK_MHZ * 1)
`define SBT_NUM_BP 10
`define SBT_MAP_NONE 4'h0_00F
`define SBT_TRACE_EXT_CYCLES 128
`define SBT_PASS_MAX 8'h0_0FF
`define SBT_US_PER_MS 1000
`define SBT_US_PER_SEC 1000000
`define SBT_US_PER_MIN 60000000

`endif

// [sbt_pkg.sv]
// Purpose: Types for the sequential breakpoint trigger.
// Assumes: Nothing beyond the constants header.
// Notes: Term maps above nine mean unmapped.
package sbt_pkg;

  typedef enum logic [2:0] {
    SBT_COND_ANY = 3'h1,
    SBT_COND_AB_C = 3'h2,
    SBT_COND_ABC_D = 3'h3,
    SBT_COND_A_BC_D = 3'h4,
    SBT_COND_AB_C2_D = 3'h5,
    SBT_COND_TIMEOUT = 3'h6
  } sbt_cond_e;

  typedef struct packed {
    logic [3:0] map_a;
    logic [3:0] map_b;
    logic [3:0] map_c;
    logic [3:0] map_d;
  } sbt_map_s;

  typedef struct packed {
    logic [7:0] minutes;
    logic [5:0] seconds;
    logic [9:0] millis;
    logic [9:0] micros;
  } sbt_time_s;

  typedef struct packed {
    logic a;
    logic b;
    logic c;
    logic d;
  } sbt_terms_s;

endpackage : sbt_pkg

// [sbt_term_map.sv]
// Purpose: Routes comparator matches onto the four sequence terms.
// Assumes: Matches are one-cycle pulses synchronous to clk.
// Notes: Purely combinational.
`timescale 1ns/100ps
`default_nettype none
`include "sbt_cfg.svh"

module sbt_term_map (
  // Comparator side
  input wire logic [9:0] bp_match,
  input wire sbt_pkg::sbt_map_s term_map,
  input wire logic seq_enable,
  // Sequence side
  output var sbt_pkg::sbt_terms_s terms,
  output logic [9:0] bp_solo
);

  wire [3:0] sel [4];
  wire [9:0] used [4];
  wire [3:0] hit;
  assign sel[0] = term_map.map_a;
  assign sel[1] = term_map.map_b;
  assign sel[2] = term_map.map_c;
  assign sel[3] = term_map.map_d;

  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_term
      // Out-of-range index never matches
      assign hit[i] = (sel[i] < 4'(`SBT_NUM_BP)) ? bp_match[sel[i]] : 1'b0;
      assign used[i] = (sel[i] < 4'(`SBT_NUM_BP)) ? (10'h0_001 << sel[i]) : 10'h0_000;
    end
  endgenerate

  assign terms = {hit[0], hit[1], hit[2], hit[3]};
  // Mapped breakpoints are kept out of bp_solo only while the sequence is enabled
  assign bp_solo = bp_match & ~(seq_enable ? (used[0] | used[1] | used[2] | used[3]) : 10'h0_000);

endmodule : sbt_term_map
`default_nettype wire

// [sbt_target_model.sv]
// Purpose: Stand-in for the comparators and the target run control.
// Assumes: Called from the bench 1 ns after a rising edge.
// Notes: Counts every cycle the trap request is seen.
`timescale 1ns/100ps
`default_nettype none

module sbt_target_model (
  // Clock
  input wire logic clk,
  // Target control
  input wire logic stop_req,
  // Comparators
  output var logic [9:0] bp_match
);
  int n_stop = 0;

  initial bp_match = 10'h000;

  // One call is one cycle; the match value holds until the next call changes it
  task automatic step(input logic [9:0] m);
    bp_match = m;
    @(posedge clk);
    #1;
  endtask : step

  always @(posedge clk) begin
    if (stop_req === 1'b1) begin
      n_stop <= n_stop + 1;
    end
  end
endmodule : sbt_target_model
`default_nettype wire

// [tb_sbt_seq_trigger.sv]
// Purpose: Self-checking bench for the sequential trigger.
// Assumes: Inputs change 1 ns after each rising edge.
// Notes: Interval limit kept at three microseconds.
`timescale 1ns/100ps
`default_nettype none

module tb_sbt_seq_trigger;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic seq_enable = 1'b0;
  logic run_en = 1'b1;
  logic [2:0] cond_sel = 3'h1;
  sbt_pkg::sbt_map_s term_map = 16'h0123;
  logic [7:0] pass_count = 8'h01;
  logic trace_after = 1'b0;
  sbt_pkg::sbt_time_s timeout = 34'h0_0000_0003;
  wire logic [9:0] bp_match;
  wire logic stop_req;
  wire logic [9:0] bp_stop;
  wire logic trace_run;
  wire logic [7:0] pass_left;
  wire logic [1:0] arm_state;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cycles = 0;
  int base;
  int n;

  sbt_seq_trigger u_sbt_seq_trigger (.clk(clk), .rst_n(rst_n), .bp_match(bp_match), .seq_enable(seq_enable),
    .cond_sel(cond_sel), .term_map(term_map), .pass_count(pass_count), .trace_after(trace_after),
    .timeout(timeout), .stop_req(stop_req), .bp_stop(bp_stop), .trace_run(trace_run), .arm_state(arm_state),
    .pass_left(pass_left));
  sbt_target_model u_sbt_target_model (.clk(clk), .stop_req(stop_req), .bp_match(bp_match));

  initial begin
    forever #4 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test

  // Whole run needs about 1800 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 10000) begin
      n_mismatch++;
      finish_test();
    end
  end

  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("FAIL %s expected %0h seen %0h", w, e, g);
      n_mismatch++;
    end
  endtask : chk

  task automatic st(input logic [9:0] m);
    u_sbt_target_model.step(m);
  endtask : st

  function automatic int stops();
    return u_sbt_target_model.n_stop - base;
  endfunction : stops

  // Term bits a,b,c,d onto the mapped breakpoints
  function automatic logic [9:0] to_bp(input logic [3:0] t);
    logic [9:0] r;
    r = 10'h000;
    if (t[0] && term_map.map_a < 4'ha) r[term_map.map_a] = 1'b1;
    if (t[1] && term_map.map_b < 4'ha) r[term_map.map_b] = 1'b1;
    if (t[2] && term_map.map_c < 4'ha) r[term_map.map_c] = 1'b1;
    if (t[3] && term_map.map_d < 4'ha) r[term_map.map_d] = 1'b1;
    return r;
  endfunction : to_bp

  // Disable clears arming, then four term steps, first nibble first
  task automatic tr(input logic [2:0] c, input logic [15:0] s, input int e);
    seq_enable = 1'b0;
    cond_sel = c;
    st(10'h000);
    seq_enable = run_en;
    base = u_sbt_target_model.n_stop;
    for (int i = 3; i >= 0; i--) st(to_bp(s[i*4 +: 4]));
    repeat (3) st(10'h000);
    chk("stop count", e, stops());
  endtask : tr

  task automatic do_reset();
    rst_n = 1'b0;
    repeat (12) st(10'h000);
    rst_n = 1'b1;
  endtask : do_reset

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    @(posedge clk);
    #1;
    do_reset();
    chk("pass_left", 8'h01, pass_left);
    trace_after = 1'b1;
    tr(1, 16'h0000, 0);
    st(10'h001);
    chk("stop_req", 1'b1, stop_req);
    n = 0;
    while (trace_run === 1'b1 && n < 300) begin
      st(10'h000);
      n++;
    end
    chk("trace cycles", 128, n);
    repeat (5) st(10'h000);
    chk("trace_run", 1'b0, trace_run);
    // Later traps must not restart the extension
    trace_after = 1'b0;
    tr(1, 16'h1248, 4);
    tr(2, 16'h2000, 0);
    tr(2, 16'h1200, 1);
    tr(2, 16'h1420, 0);
    tr(2, 16'h1120, 1);
    tr(3, 16'h1240, 1);
    st(to_bp(4'h1));
    st(to_bp(4'h2));
    chk("arm_state", 2'h1, arm_state);
    st(10'h000);
    chk("arm_state", 2'h2, arm_state);
    tr(3, 16'h1400, 0);
    tr(3, 16'h1284, 0);
    tr(3, 16'h2140, 0);
    tr(4, 16'h1400, 1);
    tr(4, 16'h1820, 0);
    tr(4, 16'h4000, 0);
    tr(5, 16'h2400, 1);
    tr(5, 16'h1840, 0);
    tr(5, 16'h4000, 0);
    tr(7, 16'h1248, 0);
    tr(0, 16'h1248, 0);
    run_en = 1'b0;
    tr(1, 16'h1248, 0);
    st(10'h3ff);
    chk("bp_stop", 10'h3ff, bp_stop);
    run_en = 1'b1;
    tr(7, 16'h0000, 0);
    st(10'h3ff);
    chk("bp_stop", 10'h3f0, bp_stop);
    term_map.map_d = 4'hf;
    tr(1, 16'h8000, 0);
    tr(3, 16'h1284, 1);
    term_map = 16'h9523;
    tr(2, 16'h1200, 1);
    term_map = 16'h0123;
    pass_count = 8'h03;
    tr(1, 16'h1100, 0);
    tr(1, 16'h1111, 1);
    chk("pass_left", 8'h02, pass_left);
    pass_count = 8'hff;
    tr(1, 16'h0000, 0);
    repeat (254) st(10'h001);
    st(10'h000);
    chk("stop count", 0, stops());
    st(10'h001);
    repeat (3) st(10'h000);
    chk("stop count", 1, stops());
    do_reset();
    pass_count = 8'h03;
    trace_after = 1'b1;
    tr(6, 16'h1000, 0);
    repeat (200) st(10'h000);
    st(10'h001);
    repeat (200) st(10'h000);
    chk("stop count", 0, stops());
    n = 200;
    while (stop_req !== 1'b1 && n < 500) begin
      st(10'h000);
      n++;
    end
    chk("timeout window", 1'b1, n >= 240 && n <= 400);
    st(10'h000);
    chk("trace_run", 1'b0, trace_run);
    chk("stop count", 1, stops());
    base = u_sbt_target_model.n_stop;
    st(10'h001);
    repeat (100) st(10'h000);
    st(10'h002);
    repeat (500) st(10'h000);
    chk("stop count", 0, stops());
    finish_test();
  end
endmodule : tb_sbt_seq_trigger
`default_nettype wire
